// File: rtl/gio_pkg.sv
/*
  Package for the general purpose I/O port block: register byte offsets,
  bit positions of the shared pull-up and reduced-drive registers, pin masks
  and bus state encoding.
  Assumes a 32-bit AHB-Lite bus with one register per aligned word.
*/
package gio_pkg;

  localparam int         PORT_W    = 8;
  localparam int         NUM_PORTS = 6;
  localparam int         PIN_W     = PORT_W * NUM_PORTS;
  localparam int         AW        = 7;

  // Byte offsets of the registers
  localparam logic [6:0] OFS_A_DATA    = 7'h00;
  localparam logic [6:0] OFS_A_DIR     = 7'h04;
  localparam logic [6:0] OFS_B_DATA    = 7'h08;
  localparam logic [6:0] OFS_B_DIR     = 7'h0C;
  localparam logic [6:0] OFS_E_DATA    = 7'h10;
  localparam logic [6:0] OFS_E_DIR     = 7'h14;
  localparam logic [6:0] OFS_E_ASSIGN  = 7'h18;
  localparam logic [6:0] OFS_H_DATA    = 7'h1C;
  localparam logic [6:0] OFS_H_DIR     = 7'h20;
  localparam logic [6:0] OFS_J_DATA    = 7'h24;
  localparam logic [6:0] OFS_J_DIR     = 7'h28;
  localparam logic [6:0] OFS_K_DATA    = 7'h2C;
  localparam logic [6:0] OFS_K_DIR     = 7'h30;
  localparam logic [6:0] OFS_WAKE_POL  = 7'h34;
  localparam logic [6:0] OFS_WAKE_IE   = 7'h38;
  localparam logic [6:0] OFS_WAKE_FLAG = 7'h3C;
  localparam logic [6:0] OFS_PULLUP    = 7'h40;
  localparam logic [6:0] OFS_RDRIVE    = 7'h44;

  // Lane of each port inside the combined pin vector
  localparam int         LANE_A = 0;
  localparam int         LANE_B = 1;
  localparam int         LANE_E = 2;
  localparam int         LANE_H = 3;
  localparam int         LANE_J = 4;
  localparam int         LANE_K = 5;

  // Bit of each port in the pull-up and reduced-drive registers
  localparam int         SEL_A = 0;
  localparam int         SEL_B = 1;
  localparam int         SEL_E = 2;
  localparam int         SEL_H = 3;
  localparam int         SEL_J = 4;
  localparam int         SEL_K = 5;
  localparam int         SEL_W = 6;

  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [7:0] E_DIR_EFFECTIVE = 8'hFC;
  localparam logic [7:0] E_PULL_PINS     = 8'h8F;
  localparam logic [7:0] E_ACTIVE_PULL   = 8'h8D;
  localparam logic [7:0] K_EMUL_PINS     = 8'h87;
  localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;

  typedef enum logic [0:0] {
    GIO_ST_READY = 1'b0,
    GIO_ST_RWAIT = 1'b1
  } gio_bus_state_t;

endpackage

// File: rtl/gio_pin_sync.sv
/*
  Two-stage synchroniser for a vector of pin inputs, plus one more stage so
  that edges can be found without looking at the first flop.
  Assumes pins are asynchronous to hclk and change slower than the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gio_pin_sync
  import gio_pkg::*;
#(
  parameter int W = PIN_W
)(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_level_d
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_d_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg    <= '0;
      level_reg   <= '0;
      level_d_reg <= '0;
    end
    else
    begin
      meta_reg    <= pin_raw;
      level_reg   <= meta_reg;
      level_d_reg <= level_reg;
    end
  end

  assign pin_level   = level_reg;
  assign pin_level_d = level_d_reg;

endmodule

`default_nettype wire

// File: rtl/gio_ports.sv
/*
  General purpose I/O ports A, B, E, H, J and K with key wake-up on H and J,
  reached over an AHB-Lite slave.
  Assumes mode and emulation inputs come from logic on hclk, pins are
  asynchronous, and pad cells apply pull, pull-down and drive selects.
*/
// Design decisions made here: the AHB-Lite register port and the register addresses.
// Summary of operation
// - Every port has a data register readable and writable whenever the port is in the map, and a per-pin direction register except where pins are input only.
// - After reset every general purpose pin is an input.
// - A direction bit of one makes the pin an output, zero an input, and all direction registers reset to zero.
// - In expanded and peripheral modes the port A and B data and direction registers leave the map.
// - A port's pull-up enable bit pulls up its input pins, and the pull-up register leaves the map in peripheral mode.
// - A reduced-drive bit lowers all outputs of its port; the register takes one write after reset and leaves the map in peripheral mode.
// - Port E pins 1 and 0 are input only and stay readable while used as interrupt request inputs.
// - The port E pin assignment overrides the port E direction bits, and only direction bits 7 to 2 act.
// - The port E pull-up bit pulls pins 7, 3, 2, 1 and 0, with active devices on 7, 3, 2 and 0.
// - The port E data and direction registers leave the map in peripheral mode and in expanded modes with port E emulation.
// - Port H and J pins detect wake-up edges as inputs or outputs, and interrupt only when enabled.
// - A polarity bit of one selects rising edges and a pull-down, zero selects falling edges and a pull-up, resetting to zero.
// - In expanded or peripheral modes with page index emulation the port K registers leave the map.
// - Port K bit 3 is always a general purpose pin.
`timescale 1ns/1ps
`default_nettype none

module gio_ports
  import gio_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mode_expanded,
  input  wire logic        mode_peripheral,
  input  wire logic        page_index_emulation_en,
  input  wire logic        port_e_emulation_en,
  input  wire logic [7:0]  a_in,
  output logic      [7:0]  a_out,
  output logic      [7:0]  a_oe,
  output logic      [7:0]  a_pull,
  output logic             a_low_drive,
  input  wire logic [7:0]  b_in,
  output logic      [7:0]  b_out,
  output logic      [7:0]  b_oe,
  output logic      [7:0]  b_pull,
  output logic             b_low_drive,
  input  wire logic [7:0]  e_in,
  output logic      [7:0]  e_out,
  output logic      [7:0]  e_oe,
  output logic      [7:0]  e_pull,
  output logic      [7:0]  e_pull_active,
  output logic             e_low_drive,
  input  wire logic [7:0]  h_in,
  output logic      [7:0]  h_out,
  output logic      [7:0]  h_oe,
  output logic      [7:0]  h_pull,
  output logic      [7:0]  h_pull_down,
  output logic             h_low_drive,
  input  wire logic [7:0]  j_in,
  output logic      [7:0]  j_out,
  output logic      [7:0]  j_oe,
  output logic      [7:0]  j_pull,
  output logic      [7:0]  j_pull_down,
  output logic             j_low_drive,
  input  wire logic [7:0]  k_in,
  output logic      [7:0]  k_out,
  output logic      [7:0]  k_oe,
  output logic      [7:0]  k_pull,
  output logic             k_low_drive,
  output logic             wake_irq
);

  function automatic logic [7:0] gio_mix(input logic [7:0] dir,
                                         input logic [7:0] latch,
                                         input logic [7:0] pin);
    return (dir & latch) | (~dir & pin);
  endfunction

  function automatic logic [31:0] gio_word(input logic [7:0] v, input logic keep);
    return keep ? {24'h000000, v} : 32'h00000000;
  endfunction

  logic [PIN_W-1:0] pin_s;
  logic [PIN_W-1:0] pin_d;

  gio_pin_sync #(.W(PIN_W)) u_sync (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin_raw     ({k_in, j_in, h_in, e_in, b_in, a_in}),
    .pin_level   (pin_s),
    .pin_level_d (pin_d)
  );

  logic [7:0]       a_s;
  logic [7:0]       b_s;
  logic [7:0]       e_s;
  logic [7:0]       k_s;
  logic [15:0]      hj_s;
  logic [15:0]      hj_d;

  assign a_s  = pin_s[LANE_A*PORT_W +: PORT_W];
  assign b_s  = pin_s[LANE_B*PORT_W +: PORT_W];
  assign e_s  = pin_s[LANE_E*PORT_W +: PORT_W];
  assign k_s  = pin_s[LANE_K*PORT_W +: PORT_W];
  assign hj_s = pin_s[LANE_H*PORT_W +: 2*PORT_W];
  assign hj_d = pin_d[LANE_H*PORT_W +: 2*PORT_W];

  // Map presence per operating mode
  logic ab_here;
  logic e_here;
  logic k_here;
  logic shared_here;
  logic k_emul;

  assign ab_here     = !(mode_expanded || mode_peripheral);
  assign e_here      = !mode_peripheral && !(mode_expanded && port_e_emulation_en);
  assign k_emul      = (mode_expanded || mode_peripheral) && page_index_emulation_en;
  assign k_here      = !k_emul;
  assign shared_here = !mode_peripheral;

  // Registers
  gio_bus_state_t   st_reg, st_next;
  logic             wr_pend_reg, wr_pend_next;
  logic [AW-1:0]    addr_reg, addr_next;
  logic [31:0]      hrdata_reg, hrdata_next;
  logic [7:0]       a_data_reg, a_data_next, a_dir_reg, a_dir_next;
  logic [7:0]       b_data_reg, b_data_next, b_dir_reg, b_dir_next;
  logic [7:0]       e_data_reg, e_data_next, e_dir_reg, e_dir_next;
  logic [7:0]       e_assign_reg, e_assign_next;
  logic [7:0]       h_data_reg, h_data_next, h_dir_reg, h_dir_next;
  logic [7:0]       j_data_reg, j_data_next, j_dir_reg, j_dir_next;
  logic [7:0]       k_data_reg, k_data_next, k_dir_reg, k_dir_next;
  logic [15:0]      pol_reg, pol_next;
  logic [15:0]      ie_reg, ie_next;
  logic [15:0]      flag_reg, flag_next;
  logic [SEL_W-1:0] pull_reg, pull_next;
  logic [SEL_W-1:0] rdrv_reg, rdrv_next;
  logic             rdrv_done_reg, rdrv_done_next;

  logic [7:0]       e_dir_eff;
  logic [15:0]      wake_edge;
  logic             take;
  logic [7:0]       wb;
  logic [31:0]      rd_word;

  assign e_dir_eff = e_dir_reg & ~e_assign_reg & E_DIR_EFFECTIVE;
  // Edges seen on synchronised pins whatever the direction
  assign wake_edge = (pol_reg & hj_s & ~hj_d) | (~pol_reg & ~hj_s & hj_d);
  assign take      = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wb        = hwdata[7:0];

  always_comb
  begin
    rd_word = 32'h00000000;
    unique case (addr_reg)
      OFS_A_DATA:    rd_word = gio_word(gio_mix(a_dir_reg, a_data_reg, a_s), ab_here);
      OFS_A_DIR:     rd_word = gio_word(a_dir_reg, ab_here);
      OFS_B_DATA:    rd_word = gio_word(gio_mix(b_dir_reg, b_data_reg, b_s), ab_here);
      OFS_B_DIR:     rd_word = gio_word(b_dir_reg, ab_here);
      OFS_E_DATA:    rd_word = gio_word(gio_mix(e_dir_eff, e_data_reg, e_s), e_here);
      OFS_E_DIR:     rd_word = gio_word(e_dir_reg, e_here);
      OFS_E_ASSIGN:  rd_word = gio_word(e_assign_reg, 1'b1);
      OFS_H_DATA:    rd_word = gio_word(gio_mix(h_dir_reg, h_data_reg, hj_s[7:0]), 1'b1);
      OFS_H_DIR:     rd_word = gio_word(h_dir_reg, 1'b1);
      OFS_J_DATA:    rd_word = gio_word(gio_mix(j_dir_reg, j_data_reg, hj_s[15:8]), 1'b1);
      OFS_J_DIR:     rd_word = gio_word(j_dir_reg, 1'b1);
      OFS_K_DATA:    rd_word = gio_word(gio_mix(k_dir_reg, k_data_reg, k_s), k_here);
      OFS_K_DIR:     rd_word = gio_word(k_dir_reg, k_here);
      OFS_WAKE_POL:  rd_word = {16'h0000, pol_reg};
      OFS_WAKE_IE:   rd_word = {16'h0000, ie_reg};
      OFS_WAKE_FLAG: rd_word = {16'h0000, flag_reg};
      OFS_PULLUP:    rd_word = shared_here ? {26'h0000000, pull_reg} : 32'h00000000;
      OFS_RDRIVE:    rd_word = shared_here ? {26'h0000000, rdrv_reg} : 32'h00000000;
      default:       rd_word = 32'h00000000;
    endcase
  end

  always_comb
  begin
    st_next        = st_reg;
    wr_pend_next   = 1'b0;
    addr_next      = addr_reg;
    hrdata_next    = hrdata_reg;
    a_data_next    = a_data_reg;
    a_dir_next     = a_dir_reg;
    b_data_next    = b_data_reg;
    b_dir_next     = b_dir_reg;
    e_data_next    = e_data_reg;
    e_dir_next     = e_dir_reg;
    e_assign_next  = e_assign_reg;
    h_data_next    = h_data_reg;
    h_dir_next     = h_dir_reg;
    j_data_next    = j_data_reg;
    j_dir_next     = j_dir_reg;
    k_data_next    = k_data_reg;
    k_dir_next     = k_dir_reg;
    pol_next       = pol_reg;
    ie_next        = ie_reg;
    flag_next      = flag_reg;
    pull_next      = pull_reg;
    rdrv_next      = rdrv_reg;
    rdrv_done_next = rdrv_done_reg;

    // Write data phase; absent registers swallow the write
    if (wr_pend_reg)
    begin
      unique case (addr_reg)
        OFS_A_DATA:    if (ab_here) a_data_next = wb;
        OFS_A_DIR:     if (ab_here) a_dir_next = wb;
        OFS_B_DATA:    if (ab_here) b_data_next = wb;
        OFS_B_DIR:     if (ab_here) b_dir_next = wb;
        OFS_E_DATA:    if (e_here) e_data_next = wb;
        OFS_E_DIR:     if (e_here) e_dir_next = wb;
        OFS_E_ASSIGN:  e_assign_next = wb;
        OFS_H_DATA:    h_data_next = wb;
        OFS_H_DIR:     h_dir_next = wb;
        OFS_J_DATA:    j_data_next = wb;
        OFS_J_DIR:     j_dir_next = wb;
        OFS_K_DATA:    if (k_here) k_data_next = wb;
        OFS_K_DIR:     if (k_here) k_dir_next = wb;
        OFS_WAKE_POL:  pol_next = hwdata[15:0];
        OFS_WAKE_IE:   ie_next = hwdata[15:0];
        OFS_WAKE_FLAG: flag_next = flag_reg & ~hwdata[15:0];
        OFS_PULLUP:    if (shared_here) pull_next = hwdata[SEL_W-1:0];
        OFS_RDRIVE:
          if (shared_here && !rdrv_done_reg)
          begin
            rdrv_next      = hwdata[SEL_W-1:0];
            rdrv_done_next = 1'b1;
          end
        default:       ;
      endcase
    end

    // A new edge wins over a clear in the same cycle
    flag_next = flag_next | wake_edge;

    unique case (st_reg)
      GIO_ST_READY:
        if (take)
        begin
          addr_next    = haddr[AW-1:0];
          wr_pend_next = hwrite;
          if (!hwrite)
            st_next = GIO_ST_RWAIT;
        end
      GIO_ST_RWAIT:
      begin
        // One wait state so a write just landed is seen by the read
        hrdata_next = rd_word;
        st_next     = GIO_ST_READY;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg        <= GIO_ST_READY;
      wr_pend_reg   <= 1'b0;
      addr_reg      <= '0;
      hrdata_reg    <= 32'h00000000;
      a_data_reg    <= BYTE_ZERO;
      a_dir_reg     <= BYTE_ZERO;
      b_data_reg    <= BYTE_ZERO;
      b_dir_reg     <= BYTE_ZERO;
      e_data_reg    <= BYTE_ZERO;
      e_dir_reg     <= BYTE_ZERO;
      e_assign_reg  <= BYTE_ZERO;
      h_data_reg    <= BYTE_ZERO;
      h_dir_reg     <= BYTE_ZERO;
      j_data_reg    <= BYTE_ZERO;
      j_dir_reg     <= BYTE_ZERO;
      k_data_reg    <= BYTE_ZERO;
      k_dir_reg     <= BYTE_ZERO;
      pol_reg       <= 16'h0000;
      ie_reg        <= 16'h0000;
      flag_reg      <= 16'h0000;
      pull_reg      <= '0;
      rdrv_reg      <= '0;
      rdrv_done_reg <= 1'b0;
    end
    else
    begin
      st_reg        <= st_next;
      wr_pend_reg   <= wr_pend_next;
      addr_reg      <= addr_next;
      hrdata_reg    <= hrdata_next;
      a_data_reg    <= a_data_next;
      a_dir_reg     <= a_dir_next;
      b_data_reg    <= b_data_next;
      b_dir_reg     <= b_dir_next;
      e_data_reg    <= e_data_next;
      e_dir_reg     <= e_dir_next;
      e_assign_reg  <= e_assign_next;
      h_data_reg    <= h_data_next;
      h_dir_reg     <= h_dir_next;
      j_data_reg    <= j_data_next;
      j_dir_reg     <= j_dir_next;
      k_data_reg    <= k_data_next;
      k_dir_reg     <= k_dir_next;
      pol_reg       <= pol_next;
      ie_reg        <= ie_next;
      flag_reg      <= flag_next;
      pull_reg      <= pull_next;
      rdrv_reg      <= rdrv_next;
      rdrv_done_reg <= rdrv_done_next;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = (st_reg == GIO_ST_READY);
  assign hresp     = 1'b0;

  // Pin side; ports A and B in bus modes and the port K emulation pins drive nothing, port E keeps driving
  assign a_out = a_data_reg;
  assign b_out = b_data_reg;
  assign e_out = e_data_reg;
  assign h_out = h_data_reg;
  assign j_out = j_data_reg;
  assign k_out = k_data_reg;

  assign a_oe = ab_here ? a_dir_reg : BYTE_ZERO;
  assign b_oe = ab_here ? b_dir_reg : BYTE_ZERO;
  assign e_oe = e_dir_eff;
  assign h_oe = h_dir_reg;
  assign j_oe = j_dir_reg;
  assign k_oe = k_emul ? (k_dir_reg & ~K_EMUL_PINS) : k_dir_reg;

  assign a_pull        = {PORT_W{pull_reg[SEL_A]}} & ~a_oe;
  assign b_pull        = {PORT_W{pull_reg[SEL_B]}} & ~b_oe;
  assign e_pull        = {PORT_W{pull_reg[SEL_E]}} & ~e_oe & E_PULL_PINS;
  assign e_pull_active = e_pull & E_ACTIVE_PULL;
  assign h_pull        = {PORT_W{pull_reg[SEL_H]}} & ~h_oe;
  assign j_pull        = {PORT_W{pull_reg[SEL_J]}} & ~j_oe;
  assign k_pull        = {PORT_W{pull_reg[SEL_K]}} & ~k_oe;
  assign h_pull_down   = pol_reg[7:0];
  assign j_pull_down   = pol_reg[15:8];

  assign a_low_drive = rdrv_reg[SEL_A];
  assign b_low_drive = rdrv_reg[SEL_B];
  assign e_low_drive = rdrv_reg[SEL_E];
  assign h_low_drive = rdrv_reg[SEL_H];
  assign j_low_drive = rdrv_reg[SEL_J];
  assign k_low_drive = rdrv_reg[SEL_K];

  assign wake_irq = |(flag_reg & ie_reg);

endmodule

`default_nettype wire

// File: test/gio_ports_props.sv
/*
  Checker for the I/O port block: bus answer timing, pin direction and pulls.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module gio_ports_props
  import gio_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       mode_expanded,
  input wire logic       mode_peripheral,
  input wire logic       page_index_emulation_en,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] e_oe,
  input wire logic [7:0] h_oe,
  input wire logic [7:0] j_oe,
  input wire logic [7:0] k_oe,
  input wire logic [7:0] a_pull,
  input wire logic [7:0] b_pull,
  input wire logic [7:0] e_pull,
  input wire logic [7:0] k_pull,
  input wire logic [7:0] e_pull_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic taken = hsel & hready & (htrans == HTRANS_NONSEQ);

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  write_fast_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  reset_input_a: assert property ($rose(hresetn) |-> {a_oe, b_oe, e_oe, h_oe, j_oe, k_oe} == 48'h0)
    else $error("pin driven right after reset");
  e_input_only_a: assert property (e_oe[1:0] == 2'b00)
    else $error("input-only port E pin driven");
  ab_absent_a: assert property (mode_expanded || mode_peripheral |-> (a_oe | b_oe) == 8'h00)
    else $error("port A or B driven in bus mode");
  k_absent_a: assert property ((mode_expanded || mode_peripheral) && page_index_emulation_en
    |-> (k_oe & 8'h87) == 8'h00)
    else $error("port K emulation pin driven");
  pull_inputs_a: assert property (((a_pull & a_oe) | (b_pull & b_oe) | (e_pull & e_oe)
    | (k_pull & k_oe)) == 8'h00)
    else $error("pull enabled on an output");
  e_pull_pins_a: assert property ((e_pull & 8'h70) == 8'h00 && e_pull_active == (e_pull & 8'h8D))
    else $error("port E pull pins wrong");
endmodule

`default_nettype wire

// File: test/gio_pin_model.sv
/*
  External circuits on the port pins: drivers, pull loads and open lines.
  Assumes a driven output wins; an unloaded open line wanders every cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module gio_pin_model #(
  parameter int W = 48
)(
  input  wire logic         hclk,
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  input  wire logic [W-1:0] pull_en,
  input  wire logic [W-1:0] pull_dn,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin_lvl
);
  logic [W-1:0] float_q = '0;

  // Open lines change each cycle so a stale value is never read as valid
  always_ff @(posedge hclk)
    float_q <= ~float_q;

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (drv_oe[i])
        pin_lvl[i] = drv_out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else if (pull_en[i])
        pin_lvl[i] = ~pull_dn[i];
      else
        pin_lvl[i] = float_q[i];
    end
  end
endmodule

`default_nettype wire

// File: test/test_gio_ports.sv
/*
  Self-checking bench for the I/O port block over AHB-Lite.
  Assumes the pin model stands on every pin and hready follows hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none

module test_gio_ports
  import gio_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake_irq;
  logic        m_exp, m_per, pie_en, eme_en;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [47:0] oe_all, out_all, pull_all, pin_lvl, ext_val, ext_en;
  logic [7:0]  e_pull_act, h_dn, j_dn;
  logic [5:0]  low_drv;
  int          err_total, checks;
  localparam logic [6:0] DIRS [6] = '{OFS_A_DIR, OFS_B_DIR, OFS_E_DIR, OFS_H_DIR, OFS_J_DIR, OFS_K_DIR};
  localparam logic [6:0] DATS [6] = '{OFS_A_DATA, OFS_B_DATA, OFS_E_DATA, OFS_H_DATA, OFS_J_DATA, OFS_K_DATA};

  gio_ports i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mode_expanded(m_exp), .mode_peripheral(m_per),
    .page_index_emulation_en(pie_en), .port_e_emulation_en(eme_en),
    .a_in(pin_lvl[7:0]), .a_out(out_all[7:0]), .a_oe(oe_all[7:0]), .a_pull(pull_all[7:0]),
    .a_low_drive(low_drv[0]), .b_in(pin_lvl[15:8]), .b_out(out_all[15:8]),
    .b_oe(oe_all[15:8]), .b_pull(pull_all[15:8]), .b_low_drive(low_drv[1]),
    .e_in(pin_lvl[23:16]), .e_out(out_all[23:16]), .e_oe(oe_all[23:16]),
    .e_pull(pull_all[23:16]), .e_pull_active(e_pull_act), .e_low_drive(low_drv[2]),
    .h_in(pin_lvl[31:24]), .h_out(out_all[31:24]), .h_oe(oe_all[31:24]),
    .h_pull(pull_all[31:24]), .h_pull_down(h_dn), .h_low_drive(low_drv[3]),
    .j_in(pin_lvl[39:32]), .j_out(out_all[39:32]), .j_oe(oe_all[39:32]),
    .j_pull(pull_all[39:32]), .j_pull_down(j_dn), .j_low_drive(low_drv[4]),
    .k_in(pin_lvl[47:40]), .k_out(out_all[47:40]), .k_oe(oe_all[47:40]),
    .k_pull(pull_all[47:40]), .k_low_drive(low_drv[5]), .wake_irq(wake_irq)
  );

  gio_pin_model #(.W(PIN_W)) i_pins (
    .hclk(hclk), .drv_out(out_all), .drv_oe(oe_all), .pull_en(pull_all),
    .pull_dn({8'h00, j_dn, h_dn, 24'h0}), .ext_val(ext_val), .ext_en(ext_en),
    .pin_lvl(pin_lvl)
  );

  task automatic final_report;
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %0t bus hang", $time);
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {25'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk({16'h0, r}, {16'h0, exp});
  endtask

  task automatic t_reset;
    chk(oe_all, 48'h0);
    for (int i = 0; i < 6; i++)
      rdc(DIRS[i], 32'h0);
    rdc(OFS_WAKE_POL, 32'h0);
  endtask

  task automatic t_dir;
    ext_en  <= '1;
    ext_val <= {6{8'h33}};
    wr(OFS_E_ASSIGN, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(DIRS[i], 32'hF0);
      wr(DATS[i], 32'h5A);
    end
    #1;
    chk(oe_all, {6{8'hF0}});
    chk(out_all, {6{8'h5A}});
    for (int i = 0; i < 6; i++)
      rdc(DATS[i], 32'h53);
    wr(OFS_E_DIR, 32'hFF);
    #1;
    chk(oe_all[23:16], 8'hFC);
    wr(OFS_E_ASSIGN, 32'h0C);
    #1;
    chk(oe_all[23:16], 8'hF0);
    wr(OFS_E_ASSIGN, 32'h0);
    rdc(OFS_E_DATA, 32'h5B);
  endtask

  task automatic t_pull;
    wr(OFS_PULLUP, 32'h3F);
    #1;
    chk(pull_all, {8'h0F, 8'h0F, 8'h0F, 8'h03, 8'h0F, 8'h0F});
    wr(OFS_RDRIVE, 32'h05);
    wr(OFS_RDRIVE, 32'h3A);
    rdc(OFS_RDRIVE, 32'h05);
    chk(low_drv, 6'h05);
  endtask

  task automatic t_modes;
    wr(OFS_K_DIR, 32'hFF);
    m_exp <= 1'b1;
    wr(OFS_A_DIR, 32'hFF);
    rdc(OFS_A_DATA, 32'h0);
    chk(oe_all[15:0], 16'h0);
    pie_en <= 1'b1;
    rdc(OFS_K_DATA, 32'h0);
    chk(oe_all[47:40], 8'h78);
    eme_en <= 1'b1;
    rdc(OFS_E_DATA, 32'h0);
    m_exp <= 1'b0;
    m_per <= 1'b1;
    rdc(OFS_PULLUP, 32'h0);
    rdc(OFS_RDRIVE, 32'h0);
    m_per  <= 1'b0;
    pie_en <= 1'b0;
    eme_en <= 1'b0;
    rdc(OFS_A_DIR, 32'hF0);
    rdc(7'h48, 32'h0);
    chk(oe_all[47:40], 8'hFF);
  endtask

  task automatic t_wake;
    int n;
    wr(OFS_WAKE_POL, 32'h0001);
    wr(OFS_WAKE_IE, 32'h0001);
    #1;
    chk(h_dn, 8'h01);
    ext_val[24] <= 1'b0;
    repeat (6) @(posedge hclk);
    wr(OFS_WAKE_FLAG, 32'hFFFF);
    rdc(OFS_WAKE_FLAG, 32'h0);
    ext_val[24] <= 1'b1;
    n = 0;
    while (wake_irq !== 1'b1 && n < 16)
    begin
      @(posedge hclk);
      n++;
    end
    chk(wake_irq, 1'b1);
    rdc(OFS_WAKE_FLAG, 32'h0001);
    wr(OFS_WAKE_FLAG, 32'h0001);
    ext_val[33] <= 1'b0;
    repeat (6) @(posedge hclk);
    rdc(OFS_WAKE_FLAG, 32'h0200);
    chk(wake_irq, 1'b0);
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial
  begin
    {hresetn, hsel, hwrite, m_exp, m_per, pie_en, eme_en} = '0;
    {htrans, haddr, hwdata, ext_val, ext_en} = '0;
    hsize     = 3'h2;
    err_total = 0;
    checks    = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_dir();
    t_pull();
    t_modes();
    t_wake();
    final_report();
  end
endmodule

bind gio_ports gio_ports_props i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .mode_expanded(mode_expanded),
  .mode_peripheral(mode_peripheral), .page_index_emulation_en(page_index_emulation_en),
  .a_oe(a_oe), .b_oe(b_oe), .e_oe(e_oe), .h_oe(h_oe), .j_oe(j_oe), .k_oe(k_oe),
  .a_pull(a_pull), .b_pull(b_pull), .e_pull(e_pull), .k_pull(k_pull),
  .e_pull_active(e_pull_active)
);

`default_nettype wire
